// ### rtl/uiec_pkg.sv
// Constants for the USB IN endpoint configuration block.
// Assumes a single 32-bit AHB-Lite register bus on hclk.
package uiec_pkg;

    //////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index
    localparam logic [15:0] UIEC_IDX_REQ_TYPE   = 16'hFF28;
    localparam logic [15:0] UIEC_IDX_REQ_CODE   = 16'hFF29;
    localparam logic [15:0] UIEC_IDX_PARAM_LO   = 16'hFF2A;
    localparam logic [15:0] UIEC_IDX_PARAM_HI   = 16'hFF2B;
    localparam logic [15:0] UIEC_IDX_TARGET_LO  = 16'hFF2C;
    localparam logic [15:0] UIEC_IDX_TARGET_HI  = 16'hFF2D;
    localparam logic [15:0] UIEC_IDX_LEN_LO     = 16'hFF2E;
    localparam logic [15:0] UIEC_IDX_LEN_HI     = 16'hFF2F;
    localparam logic [15:0] UIEC_IDX_CFG        = 16'hFF30;
    localparam logic [15:0] UIEC_IDX_STS        = 16'hFF31;
    localparam logic [15:0] UIEC_IDX_MSK        = 16'hFF32;
    localparam int          UIEC_IDX_LSB        = 2;
    localparam int          UIEC_IDX_MSB        = 17;

    //////////////////////////////////////////////////////////////////////
    // Register select codes
    localparam logic [3:0]  UIEC_SEL_CFG        = 4'h8;
    localparam logic [3:0]  UIEC_SEL_STS        = 4'h9;
    localparam logic [3:0]  UIEC_SEL_MSK        = 4'hA;
    localparam logic [3:0]  UIEC_SEL_NONE       = 4'hF;

    //////////////////////////////////////////////////////////////////////
    // Configuration byte fields
    localparam int          UIEC_CFG_ON         = 7;
    localparam int          UIEC_CFG_ISO        = 6;
    localparam int          UIEC_CFG_TOGGLE     = 5;
    localparam int          UIEC_CFG_OVF        = 5;
    localparam int          UIEC_CFG_DUAL       = 4;
    localparam int          UIEC_CFG_STALL      = 3;
    localparam int          UIEC_CFG_IRQ_ON     = 2;
    localparam int          UIEC_CFG_BPS_MSB    = 4;
    localparam logic [7:0]  UIEC_CFG_RST        = 8'h00;
    localparam logic [7:0]  UIEC_SETUP_RST      = 8'h00;
    localparam logic [2:0]  UIEC_SETUP_LAST     = 3'h7;
    localparam int          UIEC_UNIT_SHIFT     = 3;

    //////////////////////////////////////////////////////////////////////
    // Interrupt status and mask layout
    localparam int          UIEC_STS_SETUP      = 0;
    localparam int          UIEC_STS_IN         = 1;
    localparam int          UIEC_STS_OVF        = 2;
    localparam logic [2:0]  UIEC_STS_RST        = 3'h0;
    localparam logic [2:0]  UIEC_MSK_RST        = 3'h0;

    typedef enum logic [1:0] {
        UIEC_RESP_NONE,
        UIEC_RESP_DATA,
        UIEC_RESP_STALL
    } uiec_resp_t;

endpackage

// ### rtl/uiec_in_ep_cfg.sv
// USB IN endpoint configuration byte, setup packet buffer and interrupts.
// Assumes SIE and buffer manager strobes are synchronous to hclk.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps

module uiec_in_ep_cfg
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic [31:0]              hrdata,
    output logic                     hresp,
    input  wire logic                setup_byte_valid,
    input  wire logic [2:0]          setup_byte_idx,
    input  wire logic [7:0]          setup_byte_data,
    input  wire logic                in_token,
    input  wire logic                in_ack,
    input  wire logic                iso_overrun,
    input  wire logic [6:0]          x_buffer_count,
    input  wire logic [7:0]          packet_buffer_length,
    output logic                     resp_valid,
    output uiec_pkg::uiec_resp_t     resp_kind,
    output logic                     data_pid_one,
    output logic                     y_buffer_sel,
    output logic                     stall_active,
    output logic                     in_endpoint_on,
    output logic [5:0]               sample_size_bytes,
    output logic [12:0]              iso_byte_count,
    output logic [10:0]              buffer_bytes,
    output logic                     irq
);
    import uiec_pkg::*;

    //////////////////////////////////////////////////////////////////////
    // State
    logic [7:0]     setup_ff [8];
    logic [7:0]     cfg_ff;
    logic [7:0]     nxt_cfg;
    logic [2:0]     sts_ff;
    logic [2:0]     nxt_sts;
    logic [2:0]     msk_ff;
    logic           wr_pend_ff;
    logic [3:0]     wsel_ff;
    logic           hreadyout_ff;
    logic [31:0]    hrdata_ff;
    logic           hresp_ff;
    logic           resp_valid_ff;
    uiec_resp_t     resp_kind_ff;
    logic           pid_one_ff;
    logic           y_sel_ff;
    logic           stall_ff;
    logic           on_ff;
    logic [5:0]     sample_ff;
    logic [12:0]    iso_cnt_ff;
    logic [10:0]    buf_bytes_ff;
    logic           irq_ff;

    logic           addr_ok;
    logic           wr_cfg;
    logic           wr_sts;
    logic           wr_msk;
    logic [7:0]     wdat;
    logic           is_iso;
    logic           in_ok;
    logic           ovf_set;
    logic           in_irq_req;
    logic           setup_done;
    logic [2:0]     set_vec;
    logic [5:0]     bps_plus1;
    logic [12:0]    iso_cnt_calc;

    //////////////////////////////////////////////////////////////////////
    // Address decode and read mux
    function automatic logic [3:0] reg_sel(input logic [31:0] a);
        logic [15:0] idx;
        idx = a[UIEC_IDX_MSB:UIEC_IDX_LSB];
        reg_sel = UIEC_SEL_NONE;
        if (a[31:UIEC_IDX_MSB+1] == 14'h0000 && a[1:0] == 2'b00)
        begin
            if (idx[15:3] == UIEC_IDX_REQ_TYPE[15:3])
                reg_sel = {1'b0, idx[2:0]};
            else if (idx == UIEC_IDX_CFG)
                reg_sel = UIEC_SEL_CFG;
            else if (idx == UIEC_IDX_STS)
                reg_sel = UIEC_SEL_STS;
            else if (idx == UIEC_IDX_MSK)
                reg_sel = UIEC_SEL_MSK;
        end
    endfunction

    function automatic logic [31:0] rd_val(input logic [3:0] sel);
        rd_val = 32'h0000_0000;
        if (sel[3] == 1'b0)
            rd_val = {24'h00_0000, setup_ff[sel[2:0]]};
        else if (sel == UIEC_SEL_CFG)
            rd_val = {24'h00_0000, cfg_ff};
        else if (sel == UIEC_SEL_STS)
            rd_val = {29'h0000_0000, sts_ff};
        else if (sel == UIEC_SEL_MSK)
            rd_val = {29'h0000_0000, msk_ff};
    endfunction

    //////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY
    assign addr_ok = hsel & hready & htrans[1];
    assign wdat    = hwdata[7:0];
    assign wr_cfg  = wr_pend_ff & (wsel_ff == UIEC_SEL_CFG);
    assign wr_sts  = wr_pend_ff & (wsel_ff == UIEC_SEL_STS);
    assign wr_msk  = wr_pend_ff & (wsel_ff == UIEC_SEL_MSK);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff   <= 1'b0;
            wsel_ff      <= UIEC_SEL_NONE;
            hreadyout_ff <= 1'b1;
            hrdata_ff    <= 32'h0000_0000;
            hresp_ff     <= 1'b0;
        end
        else
        begin
            wr_pend_ff   <= addr_ok & hwrite;
            wsel_ff      <= reg_sel(haddr);
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
            if (addr_ok & ~hwrite)
                hrdata_ff <= rd_val(reg_sel(haddr));
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Endpoint events
    assign is_iso  = cfg_ff[UIEC_CFG_ISO];
    // Only an acknowledged data packet on a live non-iso endpoint counts
    assign in_ok   = in_ack & cfg_ff[UIEC_CFG_ON] & ~is_iso
                   & ~cfg_ff[UIEC_CFG_STALL];
    assign ovf_set = iso_overrun & is_iso;
    // Iso endpoints pass the request ungated
    assign in_irq_req = in_ack & cfg_ff[UIEC_CFG_ON]
                      & (is_iso | (~cfg_ff[UIEC_CFG_STALL]
                      & cfg_ff[UIEC_CFG_IRQ_ON]));
    assign setup_done = setup_byte_valid
                      & (setup_byte_idx == UIEC_SETUP_LAST);

    //////////////////////////////////////////////////////////////////////
    // Configuration byte
    always_comb
    begin
        nxt_cfg = cfg_ff;
        if (wr_cfg)
            nxt_cfg = wdat;
        if (in_ok)
            nxt_cfg[UIEC_CFG_TOGGLE] = ~nxt_cfg[UIEC_CFG_TOGGLE];
        if (ovf_set)
            nxt_cfg[UIEC_CFG_OVF] = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cfg_ff <= UIEC_CFG_RST;
        else
            cfg_ff <= nxt_cfg;
    end

    //////////////////////////////////////////////////////////////////////
    // Setup packet buffer; host bytes win over a software write
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_setup
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    setup_ff[gi] <= UIEC_SETUP_RST;
                else if (setup_byte_valid
                         && setup_byte_idx == 3'(gi))
                    setup_ff[gi] <= setup_byte_data;
                else if (wr_pend_ff && wsel_ff == 4'(gi))
                    setup_ff[gi] <= wdat;
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////
    // Token response and buffer selection
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            resp_valid_ff <= 1'b0;
            resp_kind_ff  <= UIEC_RESP_NONE;
        end
        else
        begin
            resp_valid_ff <= in_token & cfg_ff[UIEC_CFG_ON];
            if (!(in_token & cfg_ff[UIEC_CFG_ON]))
                resp_kind_ff <= UIEC_RESP_NONE;
            else if (cfg_ff[UIEC_CFG_STALL] & ~is_iso)
                resp_kind_ff <= UIEC_RESP_STALL;
            else
                resp_kind_ff <= UIEC_RESP_DATA;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pid_one_ff <= 1'b0;
            stall_ff   <= 1'b0;
            on_ff      <= 1'b0;
        end
        else
        begin
            pid_one_ff <= cfg_ff[UIEC_CFG_TOGGLE] & ~is_iso;
            stall_ff   <= cfg_ff[UIEC_CFG_STALL] & ~is_iso;
            on_ff      <= cfg_ff[UIEC_CFG_ON];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            y_sel_ff <= 1'b0;
        else if (is_iso | ~cfg_ff[UIEC_CFG_DUAL])
            y_sel_ff <= 1'b0;
        else if (in_ok)
            y_sel_ff <= ~y_sel_ff;
    end

    //////////////////////////////////////////////////////////////////////
    // Sizes; overflow flag takes no part here
    assign bps_plus1 = {1'b0, cfg_ff[UIEC_CFG_BPS_MSB:0]} + 6'h01;
    assign iso_cnt_calc = 13'(x_buffer_count) * 13'(bps_plus1);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sample_ff    <= 6'h00;
            iso_cnt_ff   <= 13'h0000;
            buf_bytes_ff <= 11'h000;
        end
        else
        begin
            sample_ff    <= is_iso ? bps_plus1 : 6'h00;
            iso_cnt_ff   <= is_iso ? iso_cnt_calc
                                   : 13'(x_buffer_count);
            buf_bytes_ff <= {packet_buffer_length,
                             UIEC_UNIT_SHIFT'(0)};
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Interrupts: sticky status, write one to clear, set wins
    always_comb
    begin
        set_vec = 3'h0;
        set_vec[UIEC_STS_SETUP] = setup_done;
        set_vec[UIEC_STS_IN]    = in_irq_req;
        set_vec[UIEC_STS_OVF]   = ovf_set;
        nxt_sts = sts_ff;
        if (wr_sts)
            nxt_sts = sts_ff & ~wdat[2:0];
        nxt_sts = nxt_sts | set_vec;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sts_ff <= UIEC_STS_RST;
            msk_ff <= UIEC_MSK_RST;
            irq_ff <= 1'b0;
        end
        else
        begin
            sts_ff <= nxt_sts;
            if (wr_msk)
                msk_ff <= wdat[2:0];
            irq_ff <= |(sts_ff & msk_ff);
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Outputs
    assign hreadyout         = hreadyout_ff;
    assign hrdata            = hrdata_ff;
    assign hresp             = hresp_ff;
    assign resp_valid        = resp_valid_ff;
    assign resp_kind         = resp_kind_ff;
    assign data_pid_one      = pid_one_ff;
    assign y_buffer_sel      = y_sel_ff;
    assign stall_active      = stall_ff;
    assign in_endpoint_on    = on_ff;
    assign sample_size_bytes = sample_ff;
    assign iso_byte_count    = iso_cnt_ff;
    assign buffer_bytes      = buf_bytes_ff;
    assign irq               = irq_ff;

    //////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_stall_token;
        in_token && cfg_ff[UIEC_CFG_ON] && cfg_ff[UIEC_CFG_STALL] && !is_iso;
    endsequence

    sequence s_stall_answer;
        resp_valid_ff && resp_kind_ff == UIEC_RESP_STALL;
    endsequence

    a_disabled_no_answer: assert property (
        in_token && !cfg_ff[UIEC_CFG_ON] |=> !resp_valid_ff)
        else $error("disabled endpoint answered a token");

    a_setup_byte_kept: assert property (
        setup_byte_valid && !cfg_ff[UIEC_CFG_ON]
        |=> setup_ff[$past(setup_byte_idx)] == $past(setup_byte_data))
        else $error("setup byte not stored");

    a_toggle_flips: assert property (
        in_ok && !wr_cfg
        |=> cfg_ff[UIEC_CFG_TOGGLE] != $past(cfg_ff[UIEC_CFG_TOGGLE])
            ##1 pid_one_ff == $past(cfg_ff[UIEC_CFG_TOGGLE]))
        else $error("toggle or data pid wrong after ack");

    a_stall_reply: assert property (
        s_stall_token |=> s_stall_answer)
        else $error("stalled endpoint did not return stall");

    a_single_buffer: assert property (
        (!cfg_ff[UIEC_CFG_DUAL] || is_iso) |=> !y_sel_ff)
        else $error("y buffer used without dual mode");

    a_irq_gate_off: assert property (
        in_ack && !is_iso && !cfg_ff[UIEC_CFG_IRQ_ON] && !wr_sts
        && !sts_ff[UIEC_STS_IN] |=> !sts_ff[UIEC_STS_IN])
        else $error("in request passed a closed gate");

    a_ovf_sticky: assert property (
        is_iso && cfg_ff[UIEC_CFG_OVF] && !wr_cfg
        |=> cfg_ff[UIEC_CFG_OVF])
        else $error("overflow flag cleared by hardware");

    a_iso_no_toggle: assert property (
        is_iso && in_ack && !wr_cfg && !iso_overrun
        |=> $stable(cfg_ff) ##1 !pid_one_ff)
        else $error("iso endpoint changed its config byte");

    a_iso_byte_count: assert property (
        is_iso && $stable(x_buffer_count) && $stable(cfg_ff)
        |=> iso_cnt_ff == 13'($past(x_buffer_count))
            * (13'($past(cfg_ff[UIEC_CFG_BPS_MSB:0])) + 13'h0001))
        else $error("iso byte count wrong");

    a_cfg_readback: assert property (
        addr_ok && !hwrite && reg_sel(haddr) == UIEC_SEL_CFG
        |=> hreadyout_ff && hrdata_ff[7:0] == $past(cfg_ff))
        else $error("config byte read back wrong");

endmodule

// ### verification/uiec_host_model.sv
// Host and buffer manager stand-in for the endpoint strobes.
// Assumes one hclk domain; lines change by NBA after rising edges.
`timescale 1ns/1ps

module uiec_host_model
(
    input  wire logic   hclk,
    output logic        setup_byte_valid,
    output logic [2:0]  setup_byte_idx,
    output logic [7:0]  setup_byte_data,
    output logic        in_token,
    output logic        in_ack,
    output logic        iso_overrun
);
    initial
    begin
        setup_byte_valid = 1'b0;
        setup_byte_idx = 3'h0;
        setup_byte_data = 8'hA5;
        {in_token, in_ack, iso_overrun} = 3'h0;
    end

    // Byte 0 first; data churns once released
    task automatic setup_pkt(input logic [63:0] p);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge hclk);
            setup_byte_valid <= 1'b1;
            setup_byte_idx <= i[2:0];
            setup_byte_data <= p[8*i +: 8];
        end
        @(posedge hclk);
        setup_byte_valid <= 1'b0;
        setup_byte_data <= ~p[63:56];
    endtask

    // One-cycle pulse: 0 token, 1 acked data, 2 overrun
    task automatic strobe(input int k);
        @(posedge hclk);
        in_token <= (k == 0);
        in_ack <= (k == 1);
        iso_overrun <= (k == 2);
        @(posedge hclk);
        {in_token, in_ack, iso_overrun} <= 3'h0;
    endtask
endmodule

// ### verification/usb_in_endpoint_config_test.sv
// Self-checking bench for the IN endpoint configuration block.
// Assumes an AHB-Lite master here and the host model beside it.
`timescale 1ns/1ps

module usb_in_endpoint_config_test;
    import uiec_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, sbi;
    logic [7:0]  sbd, pbl;
    logic [6:0]  xbc;
    logic        sbv, tok, ack, ovr, rv, pid, ysel, stl, on, irq;
    uiec_resp_t  kind;
    logic [5:0]  ssb;
    logic [12:0] ibc;
    logic [10:0] bb;
    int          bad_count, checks_done, cyc;

    uiec_in_ep_cfg u_uiec_in_ep_cfg (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .setup_byte_valid(sbv), .setup_byte_idx(sbi),
        .setup_byte_data(sbd), .in_token(tok), .in_ack(ack),
        .iso_overrun(ovr), .x_buffer_count(xbc),
        .packet_buffer_length(pbl), .resp_valid(rv), .resp_kind(kind),
        .data_pid_one(pid), .y_buffer_sel(ysel), .stall_active(stl),
        .in_endpoint_on(on), .sample_size_bytes(ssb),
        .iso_byte_count(ibc), .buffer_bytes(bb), .irq(irq));
    uiec_host_model u_uiec_host_model (.hclk(hclk),
        .setup_byte_valid(sbv), .setup_byte_idx(sbi),
        .setup_byte_data(sbd), .in_token(tok), .in_ack(ack),
        .iso_overrun(ovr));

    always #4 hclk = ~hclk;

    ////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            bad_count++;
            close_out();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e)
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        if (g !== e)
            bad_count++;
    endtask

    // One single transfer; waits for ready in each phase
    task automatic bus(input logic w, input logic [15:0] i,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {14'h0, i, 2'b00};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, i, {24'h0, d}, x);
    endtask

    task automatic rd(input string n, input logic [15:0] i,
                      input logic [7:0] e);
        logic [31:0] x;
        bus(1'b0, i, 32'h0, x);
        chk(n, {24'h0, e}, x);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    task automatic hit(input int k);
        u_uiec_host_model.strobe(k);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd("cfg", UIEC_IDX_CFG, 8'h00);
        rd("sts", UIEC_IDX_STS, 8'h00);
        rd("msk", UIEC_IDX_MSK, 8'h00);
        rd("setup", UIEC_IDX_LEN_HI, 8'h00);
        wr(16'hFF33, 8'hFF);
        rd("unmapped", 16'hFF33, 8'h00);
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("irq", 32'h0, {31'h0, irq});
        chk("on", 32'h0, {31'h0, on});
    endtask

    task automatic t_setup();
        wr(UIEC_IDX_CFG, 8'h00);
        u_uiec_host_model.setup_pkt(64'h8877665544332211);
        for (int i = 0; i < 8; i++)
            rd("setup", UIEC_IDX_REQ_TYPE + i[15:0],
               8'(8'h11 * (i + 1)));
        rd("sts", UIEC_IDX_STS, 8'h01);
        wr(UIEC_IDX_STS, 8'h01);
        rd("sts", UIEC_IDX_STS, 8'h00);
        wr(UIEC_IDX_PARAM_LO, 8'h5A);
        rd("param", UIEC_IDX_PARAM_LO, 8'h5A);
    endtask

    task automatic t_resp();
        hit(0);
        chk("off", 32'h0, {31'h0, rv});
        wr(UIEC_IDX_CFG, 8'h80);
        hit(0);
        chk("kind", {1'b1, UIEC_RESP_DATA}, {rv, kind});
        chk("on", 32'h1, {31'h0, on});
        chk("count", 32'd10, ibc);
        wr(UIEC_IDX_CFG, 8'h88);
        hit(0);
        chk("stall", {1'b1, UIEC_RESP_STALL}, {rv, kind});
        chk("stl", 32'h1, {31'h0, stl});
        hit(1);
        wt(2);
        rd("cfg", UIEC_IDX_CFG, 8'h88);
    endtask

    task automatic t_toggle();
        wr(UIEC_IDX_CFG, 8'h93);
        hit(1);
        wt(2);
        chk("pid ysel", 32'h3, {pid, ysel});
        rd("cfg", UIEC_IDX_CFG, 8'hB3);
        hit(1);
        wt(2);
        chk("pid ysel", 32'h0, {pid, ysel});
        wr(UIEC_IDX_CFG, 8'h83);
        hit(1);
        wt(2);
        chk("single", 32'h2, {pid, ysel});
        rd("cfg", UIEC_IDX_CFG, 8'hA3);
    endtask

    task automatic t_irq();
        wr(UIEC_IDX_MSK, 8'h02);
        wr(UIEC_IDX_CFG, 8'h80);
        hit(1);
        wt(3);
        chk("gated", 32'h0, {31'h0, irq});
        rd("sts", UIEC_IDX_STS, 8'h00);
        wr(UIEC_IDX_CFG, 8'h84);
        hit(1);
        wt(3);
        chk("irq", 32'h1, {31'h0, irq});
        wr(UIEC_IDX_MSK, 8'h00);
        wt(2);
        chk("masked", 32'h0, {31'h0, irq});
        rd("sts", UIEC_IDX_STS, 8'h02);
        wr(UIEC_IDX_STS, 8'h02);
        rd("sts", UIEC_IDX_STS, 8'h00);
    endtask

    task automatic t_iso();
        wr(UIEC_IDX_CFG, 8'hC3);
        wt(1);
        chk("size", 32'd4, ssb);
        chk("bytes", 32'd40, ibc);
        chk("buf", 32'd192, bb);
        hit(1);
        wt(2);
        rd("cfg", UIEC_IDX_CFG, 8'hC3);
        chk("pid", 32'h0, {31'h0, pid});
        hit(2);
        wt(3);
        rd("ovf", UIEC_IDX_CFG, 8'hE3);
        rd("sts", UIEC_IDX_STS, 8'h06);
        hit(0);
        chk("kind", {1'b1, UIEC_RESP_DATA}, {rv, kind});
        wr(UIEC_IDX_CFG, 8'hCB);
        rd("clr", UIEC_IDX_CFG, 8'hCB);
        hit(0);
        chk("kind", {1'b1, UIEC_RESP_DATA}, {rv, kind});
        chk("size", 32'd12, {stl, ssb});
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        {hsel, hwrite} = 2'b00;
        htrans = 2'b00;
        hsize = 3'b010;
        haddr = 32'h0;
        hwdata = 32'h0;
        xbc = 7'd10;
        pbl = 8'h18;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_setup();
        t_resp();
        t_toggle();
        t_irq();
        t_iso();
        close_out();
    end
endmodule
